/* File: src/configurable_logic_cell.sv */
// configurable logic cell: selection, gating, function, polarity, edges
//
// Contract
// - four eight-input data multiplexers
// - select code picks input of same index
// - inputs 3..7: pulse_width_out_1, pulse_width_out_2, nco, sysclk, lfosc
// - selection and gating not initialised at power-up
// - gates AND chosen lines, true or inverted
// - per-gate polarity inverts gate result
// - 0x55/0xAA with polarity give AND/NAND/NOR/OR
// - empty gate gives constant from polarity
// - true and inverted together forces zero
// - one 8-bit select register per gate
// - eight functions of four gate outputs
// - result feeds peripherals, pin and feedback
// - output invert bit inverts cell result
// - polarity change counts as output edge
// - enabled rising or falling edge sets flag
// - set wins over software clear
// - reset clears the control register, cell and pin outputs and flag, and sets pin_out_en_n; selection, gating and polarity keep their values
// - keeps working in sleep
// - settings take effect at run time
// - function code decode table
// - disabled cell outputs logic zero
`timescale 1ns/1ps
`default_nettype none

module configurable_logic_cell (
    // clock and reset
    input  wire logic                                 mclk,
    input  wire logic                                 resetn,
    // signal sources
    input  wire logic_cell_pkg::source_type           sources,
    // control register write
    input  wire logic                                 ctrl_wr,
    input  wire logic_cell_pkg::cell_control_type     ctrl_wdata,
    // polarity register write
    input  wire logic                                 pol_wr,
    input  wire logic_cell_pkg::polarity_control_type pol_wdata,
    // input select write, all four line selects at once
    input  wire logic                                 sel_wr,
    input  wire logic_cell_pkg::input_select_type     sel_wdata,
    // gate select writes, one strobe per gate
    input  wire logic [3:0]                           gate_wr,
    input  wire logic [7:0]                           gate_wdata,
    // interrupt flag clear
    input  wire logic                                 flag_clear,
    // results
    output logic                                      cell_out,
    output logic                                      pin_out,
    output logic                                      pin_out_en_n,
    output logic                                      cell_irq_flag,
    output logic_cell_pkg::cell_control_type          ctrl_readback
);
    import logic_cell_pkg::*;

    // =====================================================================
    // helpers
    function automatic logic gate_eval(input logic [GATE_W-1:0] sel,
                                       input logic [NUM_LINES-1:0] d,
                                       input logic pol);
        logic acc;
        acc = 1'b1;
        for (int k = 0; k < NUM_LINES; k++) begin
            if (sel[2*k+GATE_TRUE_POS]) begin
                acc = acc & d[k];
            end
            if (sel[2*k+GATE_INV_POS]) begin
                acc = acc & ~d[k];
            end
        end
        // polarity 1 passes the AND, 0 inverts it
        return pol ? acc : ~acc;
    endfunction : gate_eval

    // =====================================================================
    // state
    cell_control_type     ctrl_r;
    cell_control_type     ctrl_nxt;
    polarity_control_type pol_r;
    polarity_control_type pol_nxt;
    input_select_type     sel_r;
    input_select_type     sel_nxt;
    gate_select_type      gate_sel_r;
    gate_select_type      gate_sel_nxt;
    logic                 cell_out_r;
    logic                 cell_out_nxt;
    logic                 pin_out_r;
    logic                 pin_out_nxt;
    logic                 pin_out_en_n_r;
    logic                 pin_out_en_n_nxt;
    logic                 flag_r;
    logic                 flag_nxt;

    logic [NUM_SOURCES-1:0] src;
    logic [NUM_LINES-1:0]   lines;
    logic [NUM_LINES-1:0]   gates;
    logic                   fn_out;
    logic                   lc_comb;
    logic                   rise_hit;
    logic                   fall_hit;
    logic                   edge_hit;

    // =====================================================================
    // configuration registers
    always_comb begin
        ctrl_nxt     = ctrl_wr ? ctrl_wdata : ctrl_r;
        pol_nxt      = pol_wr ? pol_wdata : pol_r;
        sel_nxt      = sel_wr ? sel_wdata : sel_r;
        gate_sel_nxt = gate_sel_r;
        for (int g = 0; g < NUM_LINES; g++) begin
            if (gate_wr[g]) begin
                gate_sel_nxt[g] = gate_wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= CONTROL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // kept across reset and free of power-up value
    always_ff @(posedge mclk) begin
        pol_r      <= pol_nxt;
        sel_r      <= sel_nxt;
        gate_sel_r <= gate_sel_nxt;
    end

    // =====================================================================
    // selection and gating, no dependence on any sleep state
    always_comb begin
        src               = '0;
        src[SRC_FEEDBACK] = cell_out_r;
        src[SRC_PIN_1]    = sources.pin_input_1;
        src[SRC_PIN_2]    = sources.pin_input_2;
        src[SRC_PWM_1]    = sources.pulse_width_out_1;
        src[SRC_PWM_2]    = sources.pulse_width_out_2;
        src[SRC_NCO]      = sources.numeric_osc_out;
        src[SRC_SYSCLK]   = sources.sys_clock_tap;
        src[SRC_LFOSC]    = sources.low_freq_osc;
        for (int k = 0; k < NUM_LINES; k++) begin
            lines[k] = src[sel_r[k]];
        end
        for (int g = 0; g < NUM_LINES; g++) begin
            gates[g] = gate_eval(gate_sel_r[g], lines,
                                 pol_r.gate_invert_bits[g]);
        end
    end

    logic_function u_function (
        .mclk   (mclk),
        .resetn (resetn),
        .enable (ctrl_r.cell_enable),
        .mode   (ctrl_r.function_select),
        .gates  (gates),
        .result (fn_out)
    );

    // =====================================================================
    // output stage and edge detection
    always_comb begin
        lc_comb = 1'b0;
        if (ctrl_r.cell_enable) begin
            lc_comb = fn_out ^ pol_r.output_invert;
        end
        // an invert change moves lc_comb and so is seen as an edge
        rise_hit = lc_comb & ~cell_out_r & ctrl_r.rise_irq_enable;
        fall_hit = ~lc_comb & cell_out_r & ctrl_r.fall_irq_enable;
        edge_hit = rise_hit | fall_hit;
        cell_out_nxt     = lc_comb;
        pin_out_nxt      = lc_comb & ctrl_r.pin_output_enable;
        pin_out_en_n_nxt = ~ctrl_r.pin_output_enable;
        flag_nxt         = flag_r;
        if (flag_clear) begin
            flag_nxt = FLAG_RESET;
        end
        if (edge_hit) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cell_out_r     <= 1'b0;
            pin_out_r      <= 1'b0;
            pin_out_en_n_r <= 1'b1;
            flag_r         <= FLAG_RESET;
        end else begin
            cell_out_r     <= cell_out_nxt;
            pin_out_r      <= pin_out_nxt;
            pin_out_en_n_r <= pin_out_en_n_nxt;
            flag_r         <= flag_nxt;
        end
    end

    assign cell_out      = cell_out_r;
    assign pin_out       = pin_out_r;
    assign pin_out_en_n  = pin_out_en_n_r;
    assign cell_irq_flag = flag_r;
    assign ctrl_readback = ctrl_r;

    // =====================================================================
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_disabled_zero: assert property (
        !ctrl_r.cell_enable |=> !cell_out_r)
        else $error("disabled cell output not zero");
    a_rise_flag: assert property (
        (lc_comb && !cell_out_r && ctrl_r.rise_irq_enable)
        |=> (cell_irq_flag && cell_out_r))
        else $error("rising edge did not set flag");
    a_fall_flag: assert property (
        (!lc_comb && cell_out_r && ctrl_r.fall_irq_enable)
        |=> (cell_irq_flag && !cell_out_r))
        else $error("falling edge did not set flag");
    a_no_edge_flag: assert property (
        (!cell_irq_flag && !edge_hit) |=> !cell_irq_flag)
        else $error("flag set without enabled edge");
    a_set_wins: assert property (
        (flag_clear && edge_hit) |=> cell_irq_flag)
        else $error("edge lost during flag clear");
    a_clear_works: assert property (
        (flag_clear && !edge_hit) |=> !cell_irq_flag)
        else $error("flag clear not applied");
    a_invert_edge: assert property (
        (ctrl_r.cell_enable && $past(ctrl_r.cell_enable)
         && ctrl_r.rise_irq_enable && ctrl_r.fall_irq_enable
         && $changed(pol_r.output_invert) && $stable(fn_out))
        |=> cell_irq_flag)
        else $error("polarity change raised no flag");
    a_pin_follow: assert property (
        ctrl_r.pin_output_enable |=> (pin_out == cell_out && !pin_out_en_n))
        else $error("pin does not follow cell output");
    a_gate_const: assert property (
        (gate_sel_r[0] == 8'h00) |-> (gates[0] == pol_r.gate_invert_bits[0]))
        else $error("empty gate not constant");
    a_gate_conflict: assert property (
        (gate_sel_r[0][1:0] == 2'h3)
        |-> (gates[0] == !pol_r.gate_invert_bits[0]))
        else $error("true and inverted did not force zero");
    a_ctrl_reset: assert property (
        $rose(resetn) |-> (ctrl_r == CONTROL_RESET))
        else $error("control not cleared by reset");

    // =====================================================================
    // selection, gating and output stage checks
    a_mux_pick: assert property (
        (sel_r[0] == SRC_PIN_1) |-> (lines[0] == sources.pin_input_1))
        else $error("line 1 not from its input");

    a_mux_feedback: assert property (
        (sel_r[3] == SRC_FEEDBACK) |-> (lines[3] == cell_out_r))
        else $error("line 4 not from feedback");

    a_gate_and: assert property (
        (gate_sel_r[0] == 8'h55 && pol_r.gate_invert_bits[0])
        |-> (gates[0] == &lines))
        else $error("gate 1 not AND");

    a_gate_nand: assert property (
        (gate_sel_r[0] == 8'h55 && !pol_r.gate_invert_bits[0])
        |-> (gates[0] == ~&lines))
        else $error("gate 1 not NAND");

    a_gate_nor: assert property (
        (gate_sel_r[0] == 8'hAA && pol_r.gate_invert_bits[0])
        |-> (gates[0] == ~|lines))
        else $error("gate 1 not NOR");

    a_gate_or: assert property (
        (gate_sel_r[0] == 8'hAA && !pol_r.gate_invert_bits[0])
        |-> (gates[0] == |lines))
        else $error("gate 1 not OR");

    a_pin_released: assert property (
        !ctrl_r.pin_output_enable |=> (pin_out_en_n && !pin_out))
        else $error("pin driven while disabled");

    a_out_invert: assert property (
        (ctrl_r.cell_enable && pol_r.output_invert)
        |=> (cell_out_r == !$past(fn_out)))
        else $error("output invert not applied");

    c_flag_rise: cover property (!cell_irq_flag ##1 cell_irq_flag);
    c_pin_driven: cover property (!pin_out_en_n && pin_out);
    c_set_clear: cover property (flag_clear && edge_hit);
    c_flop_toggle: cover property (
        ctrl_r.function_select == FN_JK_R && $changed(cell_out_r));
    c_invert_edge: cover property (
        ctrl_r.cell_enable && $changed(pol_r.output_invert) ##1 cell_irq_flag);

endmodule : configurable_logic_cell

`default_nettype wire

/* File: src/logic_cell_pkg.sv */
// shared widths, encodings, source indices and carriers of the logic cell
package logic_cell_pkg;

    // =====================================================================
    // widths and counts
    localparam int NUM_LINES   = 4;
    localparam int SEL_W       = 3;
    localparam int GATE_W      = 2 * NUM_LINES;
    localparam int NUM_SOURCES = 8;

    // =====================================================================
    // source indices of the input multiplexers
    localparam logic [2:0] SRC_FEEDBACK = 3'h0;
    localparam logic [2:0] SRC_PIN_1    = 3'h1;
    localparam logic [2:0] SRC_PIN_2    = 3'h2;
    localparam logic [2:0] SRC_PWM_1    = 3'h3;
    localparam logic [2:0] SRC_PWM_2    = 3'h4;
    localparam logic [2:0] SRC_NCO      = 3'h5;
    localparam logic [2:0] SRC_SYSCLK   = 3'h6;
    localparam logic [2:0] SRC_LFOSC    = 3'h7;

    // =====================================================================
    // gate select bit positions: line k uses bits 2k (true), 2k+1 (inverted)
    localparam int GATE_TRUE_POS = 0;
    localparam int GATE_INV_POS  = 1;

    // =====================================================================
    // logic function codes
    typedef enum logic [2:0] {
        FN_AND_OR    = 3'h0,
        FN_OR_XOR    = 3'h1,
        FN_AND4      = 3'h2,
        FN_SR_LATCH  = 3'h3,
        FN_DFF_SR    = 3'h4,
        FN_DFF2_R    = 3'h5,
        FN_JK_R      = 3'h6,
        FN_DLATCH_SR = 3'h7
    } function_type;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic         cell_enable;
        logic         pin_output_enable;
        logic         rise_irq_enable;
        logic         fall_irq_enable;
        function_type function_select;
    } cell_control_type;

    typedef struct packed {
        logic                 output_invert;
        logic [NUM_LINES-1:0] gate_invert_bits;
    } polarity_control_type;

    typedef logic [NUM_LINES-1:0][SEL_W-1:0] input_select_type;
    typedef logic [NUM_LINES-1:0][GATE_W-1:0] gate_select_type;

    typedef struct packed {
        logic low_freq_osc;
        logic sys_clock_tap;
        logic numeric_osc_out;
        logic pulse_width_out_2;
        logic pulse_width_out_1;
        logic pin_input_2;
        logic pin_input_1;
    } source_type;

    // =====================================================================
    // values after reset
    localparam cell_control_type CONTROL_RESET = '0;
    localparam logic             FLAG_RESET    = 1'b0;

endpackage : logic_cell_pkg

/* File: src/logic_function.sv */
// eight-way logic function stage of the logic cell
`timescale 1ns/1ps
`default_nettype none

module logic_function (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         resetn,
    // configuration
    input  wire logic                         enable,
    input  wire logic_cell_pkg::function_type mode,
    // gate outputs, index 0 is gate 1
    input  wire logic [3:0]                   gates,
    // function result
    output logic                              result
);
    import logic_cell_pkg::*;

    logic q_r;
    logic q_nxt;
    logic clk_prev_r;
    logic clk_prev_nxt;
    logic clk_rise;

    // =====================================================================
    // function evaluation
    always_comb begin
        clk_prev_nxt = gates[0];
        clk_rise     = gates[0] & ~clk_prev_r;
        q_nxt        = q_r;
        result       = 1'b0;
        unique case (mode)
            FN_AND_OR: begin
                result = (gates[0] & gates[1]) | (gates[2] & gates[3]);
            end
            FN_OR_XOR: begin
                result = (gates[0] | gates[1]) ^ (gates[2] | gates[3]);
            end
            FN_AND4: begin
                result = &gates;
            end
            FN_SR_LATCH: begin
                // reset dominates set
                if (gates[2] | gates[3]) begin
                    q_nxt = 1'b0;
                end else if (gates[0] | gates[1]) begin
                    q_nxt = 1'b1;
                end
                result = q_nxt;
            end
            FN_DFF_SR: begin
                if (gates[2]) begin
                    q_nxt = 1'b0;
                end else if (gates[3]) begin
                    q_nxt = 1'b1;
                end else if (clk_rise) begin
                    q_nxt = gates[1];
                end
                result = q_r;
            end
            FN_DFF2_R: begin
                if (gates[2]) begin
                    q_nxt = 1'b0;
                end else if (clk_rise) begin
                    q_nxt = gates[1] & gates[3];
                end
                result = q_r;
            end
            FN_JK_R: begin
                if (gates[2]) begin
                    q_nxt = 1'b0;
                end else if (clk_rise) begin
                    q_nxt = (gates[1] & ~q_r) | (~gates[3] & q_r);
                end
                result = q_r;
            end
            FN_DLATCH_SR: begin
                if (gates[2]) begin
                    q_nxt = 1'b0;
                end else if (gates[3]) begin
                    q_nxt = 1'b1;
                end else if (gates[0]) begin
                    q_nxt = gates[1];
                end
                result = q_nxt;
            end
        endcase
        // a disabled cell starts its storage from zero
        if (!enable) begin
            q_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q_r        <= 1'b0;
            clk_prev_r <= 1'b0;
        end else begin
            q_r        <= q_nxt;
            clk_prev_r <= clk_prev_nxt;
        end
    end

    // =====================================================================
    // checks
    a_and4_mode: assert property (@(posedge mclk) disable iff (!resetn)
        (mode == FN_AND4) |-> (result == &gates))
        else $error("4-input AND result wrong");
    a_flop_clear: assert property (@(posedge mclk) disable iff (!resetn)
        (enable && mode == FN_DFF2_R && gates[2] && $stable(mode))
        |=> !result)
        else $error("flip-flop reset not applied");

endmodule : logic_function

`default_nettype wire

/* File: bench/source_model.sv */
// far-side model: source signals into the cell and the cell's output pin
`timescale 1ns/1ps
`default_nettype none

module source_model (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    // source levels requested by the bench
    input  wire logic [6:0]                 want,
    // cell pin driver
    input  wire logic                       pin_out,
    input  wire logic                       pin_out_en_n,
    // towards the cell and the board
    output var  logic_cell_pkg::source_type sources,
    output logic                            pin_level
);
    import logic_cell_pkg::*;

    // =====================================================================
    // peripherals and pins change just after the clock edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sources <= '0;
        end else begin
            sources <= source_type'(want);
        end
    end

    // =====================================================================
    // pin set as output; weak pull-up holds it high when not driven
    assign pin_level = pin_out_en_n ? 1'b1 : pin_out;

endmodule : source_model

`default_nettype wire

/* File: bench/configurable_logic_cell_tb.sv */
// self-checking bench of the configurable logic cell
`timescale 1ns/1ps
`default_nettype none

module configurable_logic_cell_tb;
    import logic_cell_pkg::*;

    // =====================================================================
    // one nibble a field, two for the gate 1 byte: identity gates, gate 1 byte and polarity,
    // function, output invert, lines 4..1, expected result
    typedef struct packed {
        logic [3:0] id;
        logic [7:0] g;
        logic [3:0] p;
        logic [3:0] fn;
        logic [3:0] inv;
        logic [3:0] src;
        logic [3:0] exp;
    } row_type;

    localparam logic [31:0] ID_GATES = 32'h40100401;

    logic [31:0] rows [46] = '{
        32'h0_55_1_2_0_F_1, 32'h0_55_1_2_0_E_0, 32'h0_55_0_2_0_E_1,
        32'h0_AA_1_2_0_0_1, 32'h0_AA_1_2_0_2_0, 32'h0_AA_0_2_0_0_0,
        32'h0_AA_0_2_0_8_1, 32'h0_00_0_2_0_F_0, 32'h0_00_1_2_0_0_1,
        32'h0_03_1_2_0_F_0, 32'h1_00_0_0_0_3_1, 32'h1_00_0_0_0_5_0,
        32'h1_00_0_0_0_C_1, 32'h1_00_0_1_0_1_1, 32'h1_00_0_1_0_5_0,
        32'h1_00_0_2_0_F_1, 32'h1_00_0_2_0_7_0, 32'h1_00_0_2_1_F_0,
        32'h1_00_0_3_0_1_1, 32'h1_00_0_3_0_0_1, 32'h1_00_0_3_0_4_0,
        32'h1_00_0_3_0_5_0, 32'h1_00_0_3_0_0_0, 32'h1_00_0_4_0_4_0,
        32'h1_00_0_4_0_2_0, 32'h1_00_0_4_0_3_1, 32'h1_00_0_4_0_1_1,
        32'h1_00_0_4_0_8_1, 32'h1_00_0_4_0_4_0, 32'h1_00_0_5_0_4_0,
        32'h1_00_0_5_0_A_0, 32'h1_00_0_5_0_B_1, 32'h1_00_0_5_0_0_1,
        32'h1_00_0_5_0_1_0, 32'h1_00_0_6_0_4_0, 32'h1_00_0_6_0_2_0,
        32'h1_00_0_6_0_3_1, 32'h1_00_0_6_0_0_1, 32'h1_00_0_6_0_9_0,
        32'h1_00_0_6_0_0_0, 32'h1_00_0_6_0_B_1, 32'h1_00_0_7_0_3_1,
        32'h1_00_0_7_0_1_0, 32'h1_00_0_7_0_2_0, 32'h1_00_0_7_0_8_1,
        32'h1_00_0_7_0_4_0
    };

    logic                 mclk = 1'b0;
    logic                 resetn;
    logic                 ctrl_wr;
    cell_control_type     ctrl_wdata;
    logic                 pol_wr;
    polarity_control_type pol_wdata;
    logic                 sel_wr;
    input_select_type     sel_wdata;
    logic [3:0]           gate_wr;
    logic [7:0]           gate_wdata;
    logic                 flag_clear;
    logic [6:0]           want;
    source_type           sources;
    logic                 cell_out;
    logic                 pin_out;
    logic                 pin_out_en_n;
    logic                 cell_irq_flag;
    cell_control_type     ctrl_readback;
    logic                 pin_level;
    logic                 fb;
    row_type              r;
    int                   err_count = 0;
    int                   cmp_count = 0;

    // =====================================================================
    // design and far side
    configurable_logic_cell i_dut (
        .mclk          (mclk),
        .resetn        (resetn),
        .sources       (sources),
        .ctrl_wr       (ctrl_wr),
        .ctrl_wdata    (ctrl_wdata),
        .pol_wr        (pol_wr),
        .pol_wdata     (pol_wdata),
        .sel_wr        (sel_wr),
        .sel_wdata     (sel_wdata),
        .gate_wr       (gate_wr),
        .gate_wdata    (gate_wdata),
        .flag_clear    (flag_clear),
        .cell_out      (cell_out),
        .pin_out       (pin_out),
        .pin_out_en_n  (pin_out_en_n),
        .cell_irq_flag (cell_irq_flag),
        .ctrl_readback (ctrl_readback)
    );

    source_model i_src (
        .mclk         (mclk),
        .resetn       (resetn),
        .want         (want),
        .pin_out      (pin_out),
        .pin_out_en_n (pin_out_en_n),
        .sources      (sources),
        .pin_level    (pin_level)
    );

    always #50 mclk = ~mclk;

    // =====================================================================
    // tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic settle;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    task automatic drive(input logic [6:0] v);
        @(posedge mclk);
        want <= v;
        settle();
    endtask : drive

    task automatic wr_ctrl(input logic [6:0] v);
        @(posedge mclk);
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= cell_control_type'(v);
        @(posedge mclk);
        ctrl_wr    <= 1'b0;
    endtask : wr_ctrl

    task automatic wr_pol(input logic [4:0] v);
        @(posedge mclk);
        pol_wr    <= 1'b1;
        pol_wdata <= polarity_control_type'(v);
        @(posedge mclk);
        pol_wr    <= 1'b0;
    endtask : wr_pol

    task automatic wr_sel(input logic [11:0] v);
        @(posedge mclk);
        sel_wr    <= 1'b1;
        sel_wdata <= input_select_type'(v);
        @(posedge mclk);
        sel_wr    <= 1'b0;
    endtask : wr_sel

    task automatic wr_gates(input logic [31:0] v);
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            gate_wr    <= 4'h1 << k;
            gate_wdata <= v[8*k +: 8];
        end
        @(posedge mclk);
        gate_wr <= 4'h0;
    endtask : wr_gates

    task automatic clr_flag;
        @(posedge mclk);
        flag_clear <= 1'b1;
        @(posedge mclk);
        flag_clear <= 1'b0;
        @(negedge mclk);
    endtask : clr_flag

    // =====================================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        close_out();
    end

    // =====================================================================
    // main sequence
    initial begin
        resetn = 1'b0;
        ctrl_wr = 1'b0;
        ctrl_wdata = '0;
        pol_wr = 1'b0;
        pol_wdata = '0;
        sel_wr = 1'b0;
        sel_wdata = '0;
        gate_wr = 4'h0;
        gate_wdata = 8'h00;
        flag_clear = 1'b0;
        want = 7'h00;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        check(cell_out, 1'b0);
        check(ctrl_readback, 7'h00);
        check(pin_out_en_n, 1'b1);
        check(cell_irq_flag, 1'b0);
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        // select codes 1..7 with all four lines on the same source
        wr_sel({4{3'h1}});
        wr_gates(ID_GATES);
        wr_pol(5'h0F);
        wr_ctrl(7'b1100010);
        @(negedge mclk);
        check(ctrl_readback, 7'h62);
        for (int s = 1; s < 8; s++) begin
            wr_sel({4{3'(s)}});
            drive(7'h01 << (s - 1));
            check(cell_out, 1'b1);
            drive(~(7'h01 << (s - 1)));
            check(cell_out, 1'b0);
        end
        wr_sel({3'h4, 3'h3, 3'h2, 3'h1});
        foreach (rows[i]) begin
            r = row_type'(rows[i]);
            wr_pol({r.inv[0], r.id[0] ? 4'hF : {3'b111, r.p[0]}});
            wr_gates(r.id[0] ? ID_GATES : {24'h0, r.g});
            wr_ctrl({4'b1100, r.fn[2:0]});
            drive({3'b000, r.src});
            check(cell_out, r.exp[0]);
            check(pin_level, r.exp[0]);
        end
        // edge flag, rising and falling edges
        wr_sel({4{3'h1}});
        wr_ctrl(7'b1110010);
        drive(7'h00);
        clr_flag();
        check(cell_irq_flag, 1'b0);
        drive(7'h01);
        check(cell_irq_flag, 1'b1);
        clr_flag();
        check(cell_irq_flag, 1'b0);
        drive(7'h00);
        check(cell_irq_flag, 1'b0);
        wr_pol(5'h1F);
        settle();
        check(cell_irq_flag, 1'b1);
        clr_flag();
        wr_ctrl(7'b1101010);
        drive(7'h01);
        check(cell_irq_flag, 1'b1);
        drive(7'h00);
        check(pin_out_en_n, 1'b0);
        check(pin_out, 1'b1);
        wr_ctrl(7'b0000010);
        settle();
        check(cell_out, 1'b0);
        check(pin_out_en_n, 1'b1);
        // reset in mid-run keeps selection, gating and polarity
        wr_ctrl(7'b1100010);
        @(posedge mclk);
        resetn <= 1'b0;
        @(negedge mclk);
        check(ctrl_readback, 7'h00);
        check(cell_out, 1'b0);
        @(posedge mclk);
        resetn <= 1'b1;
        wr_ctrl(7'b1100010);
        settle();
        check(cell_out, 1'b1);
        // inverted feedback toggles; a clear during edges is lost
        wr_sel(12'h000);
        wr_ctrl(7'b1111010);
        settle();
        fb = cell_out;
        @(negedge mclk);
        check(cell_out, !fb);
        clr_flag();
        check(cell_irq_flag, 1'b1);
        wr_ctrl(7'b0000010);
        close_out();
    end

endmodule : configurable_logic_cell_tb

`default_nettype wire
